/* ssad_params.svh */
// Constants for the saturating arithmetic datapath.
`ifndef SSAD_PARAMS_SVH
`define SSAD_PARAMS_SVH
`define SSAD_WORD_W 32
`define SSAD_HALF_W 16
`define SSAD_BYTE_W 8
`define SSAD_OP_W 5
`define SSAD_FLAG_RST 1'b0
`endif

/* ssad_pkg.sv */
// Types shared by the saturating arithmetic datapath.
package ssad_pkg;
	// Operation codes presented by the decoder.
	typedef enum logic [4:0] {
		SSAD_OP_NONE,
		SSAD_OP_SIGNED_SAT_ADD32,
		SSAD_OP_SIGNED_SAT_SUB32,
		SSAD_OP_SIGNED_SAT_ADD_BYTES,
		SSAD_OP_SIGNED_SAT_ADD_HALVES,
		SSAD_OP_SIGNED_SAT_SUB_BYTES,
		SSAD_OP_SIGNED_SAT_SUB_HALVES,
		SSAD_OP_SIGNED_SAT_ADD_SUB_EXCHANGE,
		SSAD_OP_SIGNED_SAT_SUB_ADD_EXCHANGE,
		SSAD_OP_SIGNED_SAT_DOUBLE_ADD,
		SSAD_OP_SIGNED_SAT_DOUBLE_SUB,
		SSAD_OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE,
		SSAD_OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE,
		SSAD_OP_UNSIGNED_SAT_ADD_BYTES,
		SSAD_OP_UNSIGNED_SAT_ADD_HALVES,
		SSAD_OP_UNSIGNED_SAT_SUB_BYTES,
		SSAD_OP_UNSIGNED_SAT_SUB_HALVES
	} ssad_op_t;

	// One request from the decoder: operation and both operands.
	typedef struct packed {
		ssad_op_t    op;
		logic [31:0] opa;
		logic [31:0] opb;
	} ssad_req_t;

	// Condition flags carried through untouched.
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} ssad_nzcv_t;
endpackage

/* ssad_datapath.sv */
// Saturating arithmetic datapath with the sticky saturation flag.
// Function
// RULE1: Signed lane ops clamp to lane range.
// RULE2: 32-bit signed clamp sets sticky flag.
// RULE3: Byte and halfword signed ops leave flag.
// RULE4: Only status write clears; status read shows.
// RULE5: Condition flags never altered by these ops.
// RULE6: Signed add-sub-exchange lane pairing, clamped.
// RULE7: Signed sub-add-exchange lane pairing, clamped.
// RULE8: Unsigned add-sub-exchange, clamped to unsigned.
// RULE9: Unsigned sub-add-exchange, clamped to unsigned.
// RULE10: Double with clamp, then add/sub clamped.
// RULE11: Flag set on either doubling clamp.
// RULE12: Unsigned halfword add, each lane clamped.
// RULE13: Unsigned byte add, each lane clamped.
// RULE14: Unsigned halfword subtract, negatives become zero.
// RULE15: Unsigned byte subtract, each lane clamped.
// RULE16: Flag OR-updated with the result write.
`timescale 1ns/1ps
`include "ssad_params.svh"
module ssad_datapath (
	input  wire logic                clk_sys_in,      // Core clock, 20 MHz.
	input  wire logic                srst_in,         // Synchronous reset, active high.
	input  wire logic                req_valid_in,    // Operation presented this cycle.
	input  wire ssad_pkg::ssad_req_t req_in,          // Operation and operands.
	input  wire ssad_pkg::ssad_nzcv_t nzcv_in,        // Current condition flags.
	input  wire logic                status_write_op_in,  // Status write strobe.
	input  wire logic                status_write_q_in,   // Value written to the sticky flag.
	input  wire logic                status_read_op_in,   // Status read strobe.
	output logic                     res_valid_out,   // Result valid, one cycle.
	output logic [31:0]              res_out,         // Registered result.
	output ssad_pkg::ssad_nzcv_t     nzcv_out,        // Condition flags, passed unchanged.
	output logic                     status_q_out     // Sticky flag, shown only on a read.
);
	// Registered state.
	// Every output but status_q_out, an AND of two flip-flops, comes straight from a flip-flop, so the write-back path sees no adder ripple.
	logic        valid_r, valid_nxt;
	logic [31:0] res_r, res_nxt;
	logic        q_r, q_nxt;
	logic        qrd_r, qrd_nxt;
	ssad_pkg::ssad_nzcv_t nzcv_r, nzcv_nxt;

	// Per-lane results of each lane family.
	// All of them are computed every cycle and the operation code only picks one.
	// This spends adders to keep the result select shallow.
	logic [31:0] sadd8, ssub8, uadd8, usub8;
	logic [31:0] sadd16, ssub16, uadd16, usub16;
	logic [15:0] s_ht_pl, s_hb_mi, s_ht_mi, s_hb_pl;
	logic [15:0] u_ht_pl, u_hb_mi, u_ht_mi, u_hb_pl;

	// Signed clamp of a 17-bit exact value to 16 bits.
	// Overflow shows as the two top bits of the exact value disagreeing.
	function automatic logic [15:0] sclamp16(input logic [16:0] x);
		if (x[16] != x[15]) begin
			sclamp16 = x[16] ? 16'h8000 : 16'h7fff;
		end else begin
			sclamp16 = x[15:0];
		end
	endfunction

	// Unsigned clamp; the carry bit is overflow on add, borrow on subtract.
	// The caller must say which, since the carry bit alone cannot tell them apart.
	function automatic logic [15:0] uclamp16(input logic [16:0] x, input logic is_sub);
		if (x[16]) begin
			uclamp16 = is_sub ? 16'h0000 : 16'hffff;
		end else begin
			uclamp16 = x[15:0];
		end
	endfunction

	// 32-bit signed clamp of a 33-bit exact value, with saturation flag.
	// Bit 32 of the returned value marks that clamping took place.
	function automatic logic [32:0] sclamp32(input logic [32:0] x);
		if (x[32] != x[31]) begin
			sclamp32 = {1'b1, x[32] ? 32'h80000000 : 32'h7fffffff};
		end else begin
			sclamp32 = {1'b0, x[31:0]};
		end
	endfunction

	// Byte lanes; a 9-bit exact value per lane keeps the sign or carry.
	// Signed lanes copy the sign into the ninth bit; unsigned lanes extend with zero.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_byte
			logic [8:0] sa, ss, ua, us;
			assign sa = {req_in.opa[gi*8+7], req_in.opa[gi*8+:8]} + {req_in.opb[gi*8+7], req_in.opb[gi*8+:8]};
			assign ss = {req_in.opa[gi*8+7], req_in.opa[gi*8+:8]} - {req_in.opb[gi*8+7], req_in.opb[gi*8+:8]};
			assign ua = {1'b0, req_in.opa[gi*8+:8]} + {1'b0, req_in.opb[gi*8+:8]};
			assign us = {1'b0, req_in.opa[gi*8+:8]} - {1'b0, req_in.opb[gi*8+:8]};
			// Signed byte clamp; no flag output, so the sticky flag cannot move.
			assign sadd8[gi*8+:8] = (sa[8] != sa[7]) ? (sa[8] ? 8'h80 : 8'h7f) : sa[7:0]; // RULE1 RULE3
			assign ssub8[gi*8+:8] = (ss[8] != ss[7]) ? (ss[8] ? 8'h80 : 8'h7f) : ss[7:0]; // RULE1 RULE3
			// Unsigned byte lanes clamp on the carry or the borrow out of bit 7.
			assign uadd8[gi*8+:8] = ua[8] ? 8'hff : ua[7:0]; // RULE13
			assign usub8[gi*8+:8] = us[8] ? 8'h00 : us[7:0]; // RULE15
		end
		// Halfword lanes reuse the 16-bit clamp functions.
		for (gi = 0; gi < 2; gi++) begin : g_half
			logic [15:0] a, b;
			assign a = req_in.opa[gi*16+:16];
			assign b = req_in.opb[gi*16+:16];
			assign sadd16[gi*16+:16] = sclamp16({a[15], a} + {b[15], b}); // RULE1 RULE3
			assign ssub16[gi*16+:16] = sclamp16({a[15], a} - {b[15], b}); // RULE1 RULE3
			// The second argument tells the clamp whether a set carry is a borrow.
			assign uadd16[gi*16+:16] = uclamp16({1'b0, a} + {1'b0, b}, 1'b0); // RULE12
			assign usub16[gi*16+:16] = uclamp16({1'b0, a} - {1'b0, b}, 1'b1); // RULE14
		end
	endgenerate

	// Exchange lanes: top of a with bottom of b, bottom of a with top of b.
	// The signed and unsigned pairs are both kept live; only the select differs.
	assign s_ht_pl = sclamp16({req_in.opa[31], req_in.opa[31:16]} + {req_in.opb[15], req_in.opb[15:0]}); // RULE6
	assign s_hb_mi = sclamp16({req_in.opa[15], req_in.opa[15:0]} - {req_in.opb[31], req_in.opb[31:16]}); // RULE6
	assign s_ht_mi = sclamp16({req_in.opa[31], req_in.opa[31:16]} - {req_in.opb[15], req_in.opb[15:0]}); // RULE7
	assign s_hb_pl = sclamp16({req_in.opa[15], req_in.opa[15:0]} + {req_in.opb[31], req_in.opb[31:16]}); // RULE7
	assign u_ht_pl = uclamp16({1'b0, req_in.opa[31:16]} + {1'b0, req_in.opb[15:0]}, 1'b0); // RULE8
	assign u_hb_mi = uclamp16({1'b0, req_in.opa[15:0]} - {1'b0, req_in.opb[31:16]}, 1'b1); // RULE8
	assign u_ht_mi = uclamp16({1'b0, req_in.opa[31:16]} - {1'b0, req_in.opb[15:0]}, 1'b1); // RULE9
	assign u_hb_pl = uclamp16({1'b0, req_in.opa[15:0]} + {1'b0, req_in.opb[31:16]}, 1'b0); // RULE9

	// Operation select, flag update and status read; one result per cycle.
	// Defaults hold the result and copy the request strobe, and the default branch drops it, so an idle cycle or an unknown code
	// leaves the write-back path untouched.
	always_comb begin
		logic [32:0] w;
		logic [32:0] dbl;
		logic        sat;
		w        = 33'h000000000;
		dbl      = 33'h000000000;
		sat      = 1'b0;
		res_nxt  = res_r;
		valid_nxt = req_valid_in;
		nzcv_nxt = nzcv_in; // RULE5
		qrd_nxt  = 1'b0;
		if (req_valid_in) begin
			// Only the 32-bit and doubling operations can raise the sticky flag.
			case (req_in.op)
				ssad_pkg::SSAD_OP_SIGNED_SAT_ADD32: begin
					// The sum is taken one bit wider so the clamp can see the overflow.
					w = sclamp32({req_in.opa[31], req_in.opa} + {req_in.opb[31], req_in.opb}); // RULE1
					res_nxt = w[31:0];
					sat = w[32]; // RULE2
				end
				ssad_pkg::SSAD_OP_SIGNED_SAT_SUB32: begin
					// The difference uses the same one-bit-wider form.
					w = sclamp32({req_in.opa[31], req_in.opa} - {req_in.opb[31], req_in.opb}); // RULE1
					res_nxt = w[31:0];
					sat = w[32]; // RULE2
				end
				ssad_pkg::SSAD_OP_SIGNED_SAT_DOUBLE_ADD,
				ssad_pkg::SSAD_OP_SIGNED_SAT_DOUBLE_SUB: begin
					// Doubling is clamped first, so the second step sees a legal word.
					dbl = sclamp32({req_in.opb, 1'b0}); // RULE10
					if (req_in.op == ssad_pkg::SSAD_OP_SIGNED_SAT_DOUBLE_ADD) begin
						w = sclamp32({req_in.opa[31], req_in.opa} + {dbl[31], dbl[31:0]}); // RULE10
					end else begin
						w = sclamp32({req_in.opa[31], req_in.opa} - {dbl[31], dbl[31:0]}); // RULE10
					end
					res_nxt = w[31:0];
					// Either clamp marks the flag, the doubling one included.
					sat = dbl[32] | w[32]; // RULE11
				end
				// Lane operations never raise the sticky flag, whatever they clamp.
				ssad_pkg::SSAD_OP_SIGNED_SAT_ADD_BYTES:          res_nxt = sadd8;
				ssad_pkg::SSAD_OP_SIGNED_SAT_SUB_BYTES:          res_nxt = ssub8;
				ssad_pkg::SSAD_OP_SIGNED_SAT_ADD_HALVES:         res_nxt = sadd16;
				ssad_pkg::SSAD_OP_SIGNED_SAT_SUB_HALVES:         res_nxt = ssub16;
				ssad_pkg::SSAD_OP_SIGNED_SAT_ADD_SUB_EXCHANGE:   res_nxt = {s_ht_pl, s_hb_mi}; // RULE6
				ssad_pkg::SSAD_OP_SIGNED_SAT_SUB_ADD_EXCHANGE:   res_nxt = {s_ht_mi, s_hb_pl}; // RULE7
				ssad_pkg::SSAD_OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE: res_nxt = {u_ht_pl, u_hb_mi}; // RULE8
				ssad_pkg::SSAD_OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE: res_nxt = {u_ht_mi, u_hb_pl}; // RULE9
				ssad_pkg::SSAD_OP_UNSIGNED_SAT_ADD_BYTES:        res_nxt = uadd8;
				ssad_pkg::SSAD_OP_UNSIGNED_SAT_ADD_HALVES:       res_nxt = uadd16;
				ssad_pkg::SSAD_OP_UNSIGNED_SAT_SUB_BYTES:        res_nxt = usub8;
				ssad_pkg::SSAD_OP_UNSIGNED_SAT_SUB_HALVES:       res_nxt = usub16;
				default: begin
					// Unknown operations produce no result and leave the flag.
					valid_nxt = 1'b0;
				end
			endcase
		end
		// The flag only moves on a status write or a 32-bit clamp; nothing else reaches it.
		// A saturation in the same cycle as a write wins over the clear.
		q_nxt = q_r;
		if (status_write_op_in) begin
			q_nxt = status_write_q_in; // RULE4
		end
		if (sat) begin
			q_nxt = 1'b1; // RULE16 RULE2
		end
		// The read is remembered for one cycle so the flag shows together with its update.
		if (status_read_op_in) begin
			qrd_nxt = 1'b1; // RULE4
		end
	end

	// Register stage; the flag changes on the same edge as the result.
	// Reset clears the flag and the strobes; the result word starts at zero.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			valid_r <= 1'b0;
			res_r   <= 32'h00000000;
			q_r     <= `SSAD_FLAG_RST;
			qrd_r   <= 1'b0;
			nzcv_r  <= '0;
		end else begin
			valid_r <= valid_nxt;
			res_r   <= res_nxt;
			q_r     <= q_nxt; // RULE16
			qrd_r   <= qrd_nxt;
			nzcv_r  <= nzcv_nxt;
		end
	end

	// The flag is only visible while a status read is answered.
	// A core that never reads the flag sees zero here, which keeps the flag private.
	assign status_q_out  = qrd_r & q_r; // RULE4
	assign res_valid_out = valid_r;
	assign res_out       = res_r;
	assign nzcv_out      = nzcv_r; // RULE5
endmodule // ssad_datapath

/* ssad_properties.sv */
// Concurrent checks on the ports of the saturating datapath.
`timescale 1ns/1ps
module ssad_properties (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic req_valid_in,
	input wire ssad_pkg::ssad_req_t req_in,
	input wire ssad_pkg::ssad_nzcv_t nzcv_in,
	input wire logic status_write_op_in,
	input wire logic status_write_q_in,
	input wire logic status_read_op_in,
	input wire logic res_valid_out,
	input wire logic [31:0] res_out,
	input wire ssad_pkg::ssad_nzcv_t nzcv_out,
	input wire logic status_q_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	// Accepted request, and a cycle with no request and no status write.
	wire logic go_w = req_valid_in && req_in.op inside {[5'h01:5'h10]};
	wire logic idle_w = !req_valid_in && !status_write_op_in;
	wire logic lane_w = req_valid_in && req_in.op inside {[5'h03:5'h06]};
	wire logic [31:0] sum_w = req_in.opa + req_in.opb;
	// Equal signs in and another sign out is a clamped 32-bit add.
	wire logic ovf_w = go_w && req_in.op == 5'h01 && req_in.opa[31] == req_in.opb[31] && sum_w[31] != req_in.opa[31];
	sequence s_clear; status_write_op_in && !status_write_q_in && !req_valid_in; endsequence
	sequence s_read; status_read_op_in && idle_w; endsequence
	a_result_lat: assert property (go_w |=> res_valid_out)
		else $error("Result valid missing.");
	a_result_hold: assert property (!go_w |=> !res_valid_out && $stable(res_out))
		else $error("Result changed without a request.");
	a_flags_pass: assert property (1'b1 |=> nzcv_out == $past(nzcv_in))
		else $error("Condition flags altered.");
	a_status_hidden: assert property (!status_read_op_in |=> !status_q_out)
		else $error("Sticky flag shown without a read.");
	a_sat_sets: assert property (ovf_w ##1 s_read |=> status_q_out)
		else $error("Clamped add left the flag clear.");
	a_clear_only: assert property (s_clear ##1 s_read |=> !status_q_out)
		else $error("Status write did not clear the flag.");
	a_lanes_keep: assert property (s_clear ##1 (lane_w && !status_write_op_in) ##1 s_read |=> !status_q_out)
		else $error("Lane operation set the flag.");
	a_byte_clamp: assert property (go_w && req_in.op == 5'h0d && req_in.opa[7:0] == 8'hff && req_in.opb[7:0] != 8'h00
		|=> res_out[7:0] == 8'hff)
		else $error("Unsigned byte sum not clamped.");
endmodule // ssad_properties

/* ssad_regfile_model.sv */
// Register file stand-in that takes every result written back.
`timescale 1ns/1ps
module ssad_regfile_model (
	input  wire logic clk_sys_in,   // Core clock.
	input  wire logic srst_in,      // Synchronous reset.
	input  wire logic res_valid_in, // Write-back strobe.
	output int        count_out     // Results taken so far.
);
	// A result is taken only on an edge that sees its strobe high; unknown strobes are not counted.
	always @(posedge clk_sys_in) count_out <= srst_in ? 0 : count_out + (res_valid_in === 1'b1);
endmodule // ssad_regfile_model

/* ssad_datapath_bench.sv */
// Self-checking bench for the saturating datapath.
`timescale 1ns/1ps
module ssad_datapath_bench;
	logic clk_sys_in = 1'b0, srst_in = 1'b1, req_valid_in = 1'b0;
	logic status_write_op_in = 1'b0, status_write_q_in = 1'b0, status_read_op_in = 1'b0;
	ssad_pkg::ssad_req_t req_in = '0;
	ssad_pkg::ssad_nzcv_t nzcv_in = '0, nzcv_out, pn = '0;
	logic res_valid_out, status_q_out;
	logic [31:0] res_out, r_m = '0, seed = 32'h00000022;
	bit q_m, pv, pq, hit_m;
	int err_count, total_checks, n_valid, cyc_n, wb_count;
	ssad_datapath ssad_datapath_i (.clk_sys_in, .srst_in, .req_valid_in, .req_in, .nzcv_in, .status_write_op_in,
		.status_write_q_in, .status_read_op_in, .res_valid_out, .res_out, .nzcv_out, .status_q_out);
	ssad_regfile_model ssad_regfile_model_i (.clk_sys_in, .srst_in, .res_valid_in(res_valid_out), .count_out(wb_count));
	initial forever #25 clk_sys_in = ~clk_sys_in;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Lane i of width w, sign extended when s is set.
	function automatic longint ext(logic [31:0] x, int w, int i, bit s);
		longint v = (x >> (w * i)) & ((64'sh1 << w) - 64'sh1);
		return (s && v >= (64'sh1 << (w - 1))) ? v - (64'sh1 << w) : v;
	endfunction
	// Clamps to the lane range; only a 32-bit clamp marks the sticky flag.
	function automatic longint clamp(longint v, int w, bit s);
		longint lo = s ? -(64'sh1 << (w - 1)) : 64'sh0;
		longint hi = s ? (64'sh1 << (w - 1)) - 64'sh1 : (64'sh1 << w) - 64'sh1;
		if ((v < lo || v > hi) && w == 32) hit_m = 1'b1;
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction
	function automatic logic [31:0] model(int op, logic [31:0] a, logic [31:0] b);
		longint d, t;
		int w;
		bit s;
		logic [31:0] r = '0;
		hit_m = 1'b0;
		if (op inside {1, 2, 9, 10}) begin
			d = ext(b, 32, 0, 1'b1);
			if (op > 8) d = clamp(2 * d, 32, 1'b1);
			t = op[0] ? ext(a, 32, 0, 1'b1) + d : ext(a, 32, 0, 1'b1) - d;
			r = 32'(clamp(t, 32, 1'b1));
		end else if (op inside {7, 8, 11, 12}) begin
			s = op < 9;
			t = ext(a, 16, 1, s) + (op[0] ? ext(b, 16, 0, s) : -ext(b, 16, 0, s));
			d = ext(a, 16, 0, s) + (op[0] ? -ext(b, 16, 1, s) : ext(b, 16, 1, s));
			r = {16'(clamp(t, 16, s)), 16'(clamp(d, 16, s))};
		end else if (op > 0) begin
			w = op[0] ? 8 : 16;
			s = op < 7;
			for (int i = 0; i < 32 / w; i++) begin
				t = ext(a, w, i, s) + (op inside {5, 6, 15, 16} ? -ext(b, w, i, s) : ext(b, w, i, s));
				r = r | (32'(clamp(t, w, s) & ((64'sh1 << w) - 64'sh1)) << (w * i));
			end
		end
		return r;
	endfunction
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One cycle: drive new inputs, then compare what the previous inputs produced.
	task automatic cyc(int op, logic [31:0] a, logic [31:0] b, bit v, bit wr, bit wq, bit rd, logic [3:0] nz);
		logic [31:0] r;
		@(posedge clk_sys_in);
		req_valid_in <= v;
		req_in <= '{ssad_pkg::ssad_op_t'(op), a, b};
		status_write_op_in <= wr;
		status_write_q_in <= wq;
		status_read_op_in <= rd;
		nzcv_in <= nz;
		#1;
		check("res_valid_out", 32'(res_valid_out), 32'(pv));
		check("res_out", res_out, r_m);
		check("nzcv_out", 32'(nzcv_out), 32'(pn));
		check("status_q_out", 32'(status_q_out), 32'(pq));
		r = model(op, a, b);
		pv = v && op != 0;
		pn = nz;
		r_m = pv ? r : r_m;
		n_valid += pv;
		q_m = wr ? wq : q_m;
		q_m = q_m | (pv && hit_m);
		pq = rd && q_m;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// A hang stops the run well past the thousand or so cycles the tests need.
	always @(posedge clk_sys_in) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		logic [31:0] a, b, s;
		repeat (3) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		cyc(1, 32'h7fffffff, 32'h00000001, 1, 0, 0, 0, 4'h5);
		cyc(0, '0, '0, 0, 0, 0, 1, 4'ha);
		cyc(0, '0, '0, 0, 1, 0, 0, 4'h0);
		cyc(3, 32'h7f7f7f7f, 32'h01010101, 1, 0, 0, 0, 4'hf);
		cyc(0, '0, '0, 0, 0, 0, 1, 4'h3);
		cyc(9, 32'h00000000, 32'h40000000, 1, 0, 0, 0, 4'h0);
		cyc(0, '0, '0, 0, 0, 0, 1, 4'h0);
		cyc(0, '0, '0, 0, 1, 0, 0, 4'h6);
		cyc(0, '0, '0, 0, 0, 0, 1, 4'h9);
		$display("test directed done");
		for (int k = 0; k < 1000; k++) begin
			s = rnd();
			a = s[2] ? rnd() : {4{s[5:4] == 2'h0 ? 8'h7f : s[6] ? 8'h80 : 8'hff}};
			b = s[8] ? rnd() : {4{s[11:10] == 2'h0 ? 8'h01 : s[12] ? 8'h80 : 8'hff}};
			cyc(int'(rnd() % 17), a, b, s[15:14] != 2'h0, s[18:16] == 3'h0, s[19], s[20], s[24:21]);
		end
		// The last result reaches the register file model one edge after it stands.
		repeat (2) cyc(0, '0, '0, 0, 0, 0, 0, 4'h0);
		check("write_backs", 32'(wb_count), 32'(n_valid));
		$display("test random done");
		conclude();
	end
endmodule // ssad_datapath_bench
bind ssad_datapath ssad_properties ssad_properties_i (.clk_sys_in, .srst_in, .req_valid_in, .req_in, .nzcv_in,
	.status_write_op_in, .status_write_q_in, .status_read_op_in, .res_valid_out, .res_out, .nzcv_out, .status_q_out);
